//--- bench/rco_assertions.sv
/* Checker for rco_top ports: stop, clean start and pulse shapes.
   Assumes a bind into rco_top and the single clock clk_sys. */
`timescale 1ns/1ps
`default_nettype none
module rco_assertions #(parameter NUM_EXT = 3) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [NUM_EXT-1:0] ext_clk_in,
  input wire logic refclk_output_pin
);
  // ==========
  // Shadow settings; shapes are judged only after 15 quiet cycles
  logic en;
  logic [1:0] src;
  logic [2:0] dv;
  logic [1:0] dt;
  logic [3:0] q;
  wire pin = refclk_output_pin;
  wire steady = en && src == 2'h0 && q == 4'hf;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      en <= 1'b0;
      src <= 2'h0;
      q <= 4'h0;
    end else if (reg_wr) begin
      q <= 4'h0;
      if (reg_addr == 4'h1) src <= reg_wdata[1:0];
      if (reg_addr == 4'h0) begin
        en <= reg_wdata[7];
        dt <= reg_wdata[4:3];
        dv <= reg_wdata[2:0];
      end
    end else if (q != 4'hf) q <= q + 4'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_off; reg_wr && reg_addr == 4'h0 && !reg_wdata[7]; endsequence
  sequence s_on; reg_wr && reg_addr == 4'h0 && reg_wdata[7]; endsequence
  property p_stop; s_off |-> ##2 !pin; endproperty
  a_stop: assert property (p_stop) else $error("pin runs after disable");
  property p_held; s_off ##1 (!reg_wr)[*4] |-> !pin; endproperty
  a_held: assert property (p_held) else $error("pin high while disabled");
  sequence s_start; s_on ##0 (reg_wdata[2:0] == 3'h1 && reg_wdata[4:3] == 2'h2 && src == 2'h0);
  endsequence
  property p_clean; s_off ##2 s_start |-> ##[2:3] ($rose(pin) ##1 pin ##1 !pin); endproperty
  a_clean: assert property (p_clean) else $error("early pulse on enable");
  // A write aborts a shape check, since live changes may glitch
  property p_undiv; disable iff (!arst_n || reg_wr) steady && dv == 3'h0 && pin |=> !pin;
  endproperty
  a_undiv: assert property (p_undiv) else $error("undivided shape");
  property p_half; disable iff (!arst_n || reg_wr)
    steady && dv == 3'h1 && dt == 2'h2 && $rose(pin) |-> pin[*2] ##1 !pin; endproperty
  a_half: assert property (p_half) else $error("half duty shape");
  property p_q25; disable iff (!arst_n || reg_wr)
    steady && dv == 3'h1 && dt == 2'h1 && $rose(pin) |=> !pin; endproperty
  a_q25: assert property (p_q25) else $error("quarter duty shape");
  property p_q75; disable iff (!arst_n || reg_wr)
    steady && dv == 3'h1 && dt == 2'h3 && $rose(pin) |-> pin[*3] ##1 !pin; endproperty
  a_q75: assert property (p_q75) else $error("three quarter shape");
  property p_qmin; disable iff (!arst_n || reg_wr)
    steady && dv == 3'h2 && dt == 2'h0 && $fell(pin) |-> (!pin)[*7] ##1 pin; endproperty
  a_qmin: assert property (p_qmin) else $error("minimal duty shape");
endmodule // rco_assertions
bind rco_top rco_assertions #(.NUM_EXT(NUM_EXT)) u_rco_assertions (
  .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_in(ext_clk_in),
  .refclk_output_pin(refclk_output_pin));
`default_nettype wire

//--- bench/rco_sink.sv
/* Consumer of the reference clock: measures the last high and low times.
   Assumes the clock it watches is sampled on clk_sys rising edges. */
`timescale 1ns/1ps
`default_nettype none
module rco_sink (
  input wire logic clk_sys,
  input wire logic refclk_output_pin,
  output logic [7:0] hi_len,
  output logic [7:0] lo_len
);
  // ==========
  // Run length of the level seen on consecutive edges
  logic lvl;
  logic [7:0] run;
  always @(posedge clk_sys) begin
    if (refclk_output_pin === lvl) run <= run + 8'h01;
    else begin
      if (lvl) hi_len <= run;
      else lo_len <= run;
      run <= 8'h01;
    end
    lvl <= refclk_output_pin;
  end
endmodule // rco_sink
`default_nettype wire

//--- bench/tb_top.sv
/* Self-checking bench of rco_top: register tasks and one task a scenario.
   Assumes rco_sink and the checker are compiled before this file. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic run = 1'b1;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] ext_clk_in = 3'h0;
  logic [7:0] reg_rdata;
  logic refclk_output_pin;
  logic [7:0] hi_len;
  logic [7:0] lo_len;
  logic [7:0] ecnt = 8'h00;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  // Clearing run stops the clock, standing in for sleep
  always #5 if (run) clk_sys = ~clk_sys;
  rco_top u_rco_top (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_clk_in(ext_clk_in), .refclk_output_pin(refclk_output_pin));
  rco_sink u_rco_sink (.clk_sys(clk_sys), .refclk_output_pin(refclk_output_pin),
    .hi_len(hi_len), .lo_len(lo_len));
  // ==========
  // External sources of period 8, 16 and 32 cycles; run limit
  always @(posedge clk_sys) begin
    ecnt <= ecnt + 8'h01;
    ext_clk_in <= ecnt[4:2];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up;
    end
  end
  task wrap_up;
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // ==========
  // Register port and pin helpers
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, exp);
  endtask
  task wait_pin(input logic v);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (refclk_output_pin !== v && n < 600);
    chk({7'h0, refclk_output_pin}, {7'h0, v});
  endtask
  // Configure while disabled, enable, then measure the first whole pulse
  task t_shape(input logic [2:0] dv, input logic [1:0] dt, input logic [7:0] hi,
               input logic [7:0] lo);
    wr(4'h0, {3'h0, dt, dv});
    wr(4'h0, {3'h4, dt, dv});
    wait_pin(1'b1);
    wait_pin(1'b0);
    @(negedge clk_sys);
    chk(hi_len, hi);
    wait_pin(1'b1);
    @(negedge clk_sys);
    chk(lo_len, lo);
    repeat (40) @(negedge clk_sys);
  endtask
  task t_reset;
    chk({7'h0, refclk_output_pin}, 8'h00);
    rd(4'h0, 8'h10);
    rd(4'h1, 8'h00);
    wr(4'h7, 8'hff);
    rd(4'h7, 8'h00);
    rd(4'h0, 8'h10);
  endtask
  task t_stop;
    wait_pin(1'b1);
    wr(4'h0, 8'h13);
    @(negedge clk_sys);
    repeat (20) begin
      @(negedge clk_sys);
      chk({7'h0, refclk_output_pin}, 8'h00);
    end
    rd(4'h3, 8'h00);
  endtask
  task t_live;
    wr(4'h0, 8'h91);
    wait_pin(1'b1);
    wr(4'h0, 8'h92);
    // The pulse around a live write may be cut short, so let it settle
    repeat (20) @(negedge clk_sys);
    wait_pin(1'b0);
    wait_pin(1'b1);
    wait_pin(1'b0);
    @(negedge clk_sys);
    chk(hi_len, 8'h04);
    wait_pin(1'b1);
    @(negedge clk_sys);
    chk(lo_len, 8'h04);
  endtask
  task t_sleep;
    wr(4'h0, 8'h93);
    wait_pin(1'b1);
    run = 1'b0;
    #200;
    chk({7'h0, refclk_output_pin}, 8'h01);
    run = 1'b1;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset;
    for (int i = 0; i < 8; i++) t_shape(3'(i), 2'h2, 8'h01 << i, 8'h01 << i);
    t_shape(3'h1, 2'h1, 8'h01, 8'h03);
    t_shape(3'h1, 2'h3, 8'h03, 8'h01);
    t_shape(3'h2, 2'h0, 8'h01, 8'h07);
    t_shape(3'h0, 2'h1, 8'h01, 8'h01);
    t_stop;
    t_live;
    wr(4'h1, 8'h01);
    t_shape(3'h0, 2'h2, 8'h04, 8'h04);
    wr(4'h1, 8'h03);
    t_shape(3'h0, 2'h2, 8'h10, 8'h10);
    wr(4'h1, 8'h00);
    t_sleep;
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire

//--- hdl/rco_defines.vh
/*
  Constants of the reference clock output block: register offsets, field
  positions, reset values and widths.
  Assumes it is included by bare name from the design files only.
*/
`ifndef RCO_DEFINES_VH
`define RCO_DEFINES_VH

// ==========================================================
// Register offsets (register port address)
`define RCO_ADDR_W 4
`define RCO_OFS_CTRL 4'h0
`define RCO_OFS_SRC 4'h1
`define RCO_OFS_STAT 4'h2
`define RCO_OFS_CNT 4'h3

// ==========================================================
// Data width and control register fields
`define RCO_DATA_W 8
`define RCO_CTRL_DIV_LSB 0
`define RCO_CTRL_DIV_MSB 2
`define RCO_CTRL_DUTY_LSB 3
`define RCO_CTRL_DUTY_MSB 4
`define RCO_CTRL_EN_BIT 7

// ==========================================================
// Source select and status fields
`define RCO_SRC_W 2
`define RCO_STAT_PIN_BIT 0
`define RCO_STAT_RUN_BIT 1
`define RCO_STAT_BASE_BIT 2

// ==========================================================
// Reset values
`define RCO_RST_EN 1'h0
`define RCO_RST_DIV 3'h0
`define RCO_RST_DUTY 2'h2
`define RCO_RST_SRC 2'h0

// ==========================================================
// Duty field codes
`define RCO_DUTY_MIN 2'h0
`define RCO_DUTY_25 2'h1
`define RCO_DUTY_50 2'h2
`define RCO_DUTY_75 2'h3

`endif

//--- hdl/rco_sync.v
/*
  Two-flop synchronisers for the external reference clock sources.
  Assumes the inputs are asynchronous to clk_sys; only the second stage
  leaves this module.
*/
`timescale 1ns/1ps
`default_nettype none

module rco_sync #(
  parameter WIDTH = 3
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  // ==========================================================
  // Per-bit synchroniser stages
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_sync
      reg meta;
      reg stable;
      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          meta <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta <= async_in[i];
          stable <= meta;
        end
      end
      assign sync_out[i] = stable;
    end
  endgenerate

endmodule // rco_sync

`default_nettype wire

//--- hdl/rco_top.v
/*
  Reference clock output block: selects a base clock, divides it by a
  power of two from 1 to 128, shapes its duty cycle and drives the
  reference clock output pin from a flip-flop.
  Assumes a single clock domain (clk_sys), an asynchronous active-low
  reset and a register master that keeps its strobes one cycle long.
  External clock sources are asynchronous and are synchronised here.
*/
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

`include "rco_defines.vh"

// Behaviour
// - Output derives from the base clock picked by the source select register.
// - Setting enable starts the output cleanly, with no runt pulse.
// - Clearing enable stops the output at once, not at period end.
// - Divider and duty writes take effect while enabled; glitches allowed then.
// - Three-bit divider selects division by 1, 2, 4, 8, 16, 32, 64, 128.
// - Duty field gives minimal (one half base period high), 25, 50 or 75 percent; undivided passes base duty.
// - Reset sets the duty field upper bit, giving 50 percent by default.
// - When clk_sys stops in sleep the output holds its present level.
module rco_top #(
  parameter NUM_EXT = 3
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [`RCO_ADDR_W-1:0] reg_addr,
  input wire [`RCO_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`RCO_DATA_W-1:0] reg_rdata,
  input wire [NUM_EXT-1:0] ext_clk_in,
  output reg refclk_output_pin
);

  // ==========================================================
  // Registers and state
  reg refclk_output_enable;
  reg [2:0] refclk_divide_select;
  reg [1:0] refclk_duty_select;
  reg [`RCO_SRC_W-1:0] refclk_source_select_reg;
  reg int_base;
  reg base_lvl;
  reg base_prev;
  // Run states, one-hot
  // Idle holds the pin low and the counter clear until a base rising edge
  localparam ST_IDLE = 2'h1;
  localparam ST_RUN = 2'h2;
  reg [1:0] state;
  reg [7:0] half_cnt;

  wire [NUM_EXT-1:0] ext_sync;

  reg next_base_lvl;
  reg [1:0] next_state;
  reg [7:0] next_half_cnt;
  reg next_pin;
  reg [`RCO_DATA_W-1:0] next_rdata;

  // ==========================================================
  // Source synchronisers
  rco_sync #(
    .WIDTH(NUM_EXT)
  ) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .async_in(ext_clk_in),
    .sync_out(ext_sync)
  );

  // ==========================================================
  // Register writes
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      refclk_output_enable <= `RCO_RST_EN;
      refclk_divide_select <= `RCO_RST_DIV;
      refclk_duty_select <= `RCO_RST_DUTY;
      refclk_source_select_reg <= `RCO_RST_SRC;
    end else if (reg_wr) begin
      if (reg_addr == `RCO_OFS_CTRL) begin
        // Accepted at any time, also while running
        refclk_output_enable <= reg_wdata[`RCO_CTRL_EN_BIT];
        refclk_divide_select <= reg_wdata[`RCO_CTRL_DIV_MSB:`RCO_CTRL_DIV_LSB];
        refclk_duty_select <= reg_wdata[`RCO_CTRL_DUTY_MSB:`RCO_CTRL_DUTY_LSB];
      end
      if (reg_addr == `RCO_OFS_SRC) begin
        refclk_source_select_reg <= reg_wdata[`RCO_SRC_W-1:0];
      end
    end
  end

  // ==========================================================
  // Register reads: data stand only in the cycle after the strobe
  always @* begin
    next_rdata = {`RCO_DATA_W{1'b0}};
    if (reg_rd) begin
      case (reg_addr)
        `RCO_OFS_CTRL: begin
          next_rdata[`RCO_CTRL_EN_BIT] = refclk_output_enable;
          next_rdata[`RCO_CTRL_DIV_MSB:`RCO_CTRL_DIV_LSB] = refclk_divide_select;
          next_rdata[`RCO_CTRL_DUTY_MSB:`RCO_CTRL_DUTY_LSB] = refclk_duty_select;
        end
        `RCO_OFS_SRC: begin
          next_rdata[`RCO_SRC_W-1:0] = refclk_source_select_reg;
        end
        `RCO_OFS_STAT: begin
          next_rdata[`RCO_STAT_PIN_BIT] = refclk_output_pin;
          next_rdata[`RCO_STAT_RUN_BIT] = (state == ST_RUN);
          next_rdata[`RCO_STAT_BASE_BIT] = base_lvl;
        end
        `RCO_OFS_CNT: begin
          next_rdata = half_cnt;
        end
        default: begin
          next_rdata = {`RCO_DATA_W{1'b0}};
        end
      endcase
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= {`RCO_DATA_W{1'b0}};
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Base clock selection
  // The pin is a flop, so the internal base is clk_sys/2 with 50% duty;
  // the fastest reference that can leave a register is half the clock.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      int_base <= 1'b0;
    end else begin
      int_base <= ~int_base;
    end
  end

  // ==========================================================
  // Source decode
  // Code k picks ext_clk_in[k-1]; codes above NUM_EXT fall back to the internal base
  wire [31:0] src_idx = {{(32-`RCO_SRC_W){1'b0}}, refclk_source_select_reg};
  wire ext_valid = (src_idx != 32'h0) && (src_idx <= NUM_EXT);
  wire [NUM_EXT-1:0] ext_pick;

  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g = g + 1) begin : g_pick
      // Only the second synchroniser stage is read here
      assign ext_pick[g] = ext_sync[g] & (src_idx == g + 1);
    end
  endgenerate

  always @* begin
    next_base_lvl = int_base;
    if (ext_valid) begin
      next_base_lvl = |ext_pick;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      base_lvl <= 1'b0;
      base_prev <= 1'b0;
    end else begin
      base_lvl <= next_base_lvl;
      base_prev <= base_lvl;
    end
  end

  wire base_edge = base_lvl ^ base_prev;
  wire base_rise = base_lvl & ~base_prev;

  // ==========================================================
  // Period and high time in half base periods
  // Counting both base edges gives whole steps for 25% at divide by 2.
  // Table form keeps every ratio in view; entries count half base periods.
  // A change while running lands mid-period, the glitch that live writes allow.
  reg [8:0] period_len;

  always @* begin
    case (refclk_divide_select)
      3'h0: begin
        period_len = 9'h002; // Divide by 1
      end
      3'h1: begin
        period_len = 9'h004; // Divide by 2
      end
      3'h2: begin
        period_len = 9'h008; // Divide by 4
      end
      3'h3: begin
        period_len = 9'h010; // Divide by 8
      end
      3'h4: begin
        period_len = 9'h020; // Divide by 16
      end
      3'h5: begin
        period_len = 9'h040; // Divide by 32
      end
      3'h6: begin
        period_len = 9'h080; // Divide by 64
      end
      3'h7: begin
        period_len = 9'h100; // Divide by 128
      end
      default: begin
        period_len = 9'h002;
      end
    endcase
  end

  wire [8:0] period_m1 = period_len - 9'h001;
  wire [7:0] cnt_last = period_m1[7:0];
  wire [8:0] quarter = period_len >> 2;
  reg [8:0] high_len;

  always @* begin
    case (refclk_duty_select)
      `RCO_DUTY_25: begin
        high_len = quarter;
      end
      `RCO_DUTY_50: begin
        high_len = quarter << 1;
      end
      `RCO_DUTY_75: begin
        high_len = quarter + (quarter << 1);
      end
      default: begin
        high_len = 9'h001; // Minimal duty
      end
    endcase
  end

  // ==========================================================
  // Run control, counter and pin level
  always @* begin
    next_state = state;
    next_half_cnt = half_cnt;
    next_pin = refclk_output_pin;
    case (state)
      ST_IDLE: begin
        // Start only on a base rising edge so the first pulse is whole
        next_half_cnt = 8'h00;
        next_pin = 1'b0;
        if (base_rise) begin
          next_state = ST_RUN;
          next_pin = 1'b1;
        end
      end
      ST_RUN: begin
        // Pin steps on each base edge; the counter too when divided, held clear when undivided
        if (refclk_divide_select == 3'h0) begin
          next_pin = base_lvl; // Undivided passes base duty
          next_half_cnt = 8'h00;
        end else if (base_edge) begin
          // A shrunk period after a live write wraps at once
          if (half_cnt >= cnt_last) begin
            next_half_cnt = 8'h00;
          end else begin
            next_half_cnt = half_cnt + 8'h01;
          end
          next_pin = ({1'b0, next_half_cnt} < high_len);
        end
      end
      default: begin
        // Unused state codes recover to idle
        next_state = ST_IDLE;
        next_half_cnt = 8'h00;
        next_pin = 1'b0;
      end
    endcase
    if (!refclk_output_enable) begin
      // Immediate stop from any state, counter cleared for a fresh start
      next_state = ST_IDLE;
      next_half_cnt = 8'h00;
      next_pin = 1'b0;
    end
  end

  // Without clk_sys edges in sleep every flop, the pin included, holds.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      half_cnt <= 8'h00;
      refclk_output_pin <= 1'b0;
    end else begin
      state <= next_state;
      half_cnt <= next_half_cnt;
      refclk_output_pin <= next_pin;
    end
  end

endmodule // rco_top

`default_nettype wire
